// ===== rxber_core.sv
// Receive buffer selection, error reporting, fatal queue drain and boot requests
`timescale 1ns/1ps
module rxber_core
  import rxber_pkg::*;
#(
  parameter int DEPTH = Q_DEPTH,
  parameter int WIN_CYC = RETR_WIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Arriving message, head entries of the pool and private lists
  input wire rxber_rx_s rx_in,
  output rxber_rx_out_e rx_out,
  output logic rx_done,
  // Procedural errors and nonexistent memory faults
  input wire logic perr_valid,
  input wire logic [CODE_W-1:0] perr_code,
  input wire logic nxm_valid,
  input wire logic [ADDR_W-1:0] nxm_addr,
  input wire logic nxm_advanced,
  // Responses to the host
  input wire logic resp_take,
  output logic resp_valid,
  output rxber_resp_s resp_data,
  output logic resp_irq,
  // Protocol halt and restart
  input wire logic halt_trib,
  input wire logic halt_global,
  input wire logic restart,
  output logic halted,
  output logic ret_trib_bufs,
  output logic ret_pool_bufs,
  output logic halt_req,
  output logic [NAKCNT_W-1:0] nak_count,
  // Babbling and streaming monitors
  input wire logic [1:0] tmr_run,
  input wire logic [TMR_W-1:0] babble_period,
  input wire logic [TMR_W-1:0] stream_period,
  // Boot
  input wire logic poll_rx,
  input wire logic power_on_boot_en,
  input wire logic invoke_boot,
  output logic boot_req,
  // Fatal state
  output logic fatal,
  output logic shut_down
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN_CYC - 1);

  typedef enum logic [1:0] {Q_IDLE, Q_FETCH, Q_POST, Q_SHUT} rxber_q_e;

  rxber_q_e state;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [WIN_W-1:0] win_cnt;
  logic [RESP_W-1:0] mem_q;
  logic push_valid;
  rxber_resp_s push_data;
  logic accept;
  logic push_do;
  logic overflow;
  logic pop;
  logic [1:0] tmr_ev;
  logic boot_pend;
  logic [TMR_W-1:0] period [2];

  // Heads only: deeper list entries are never looked at
  function automatic rxber_rx_out_e rx_select(input rxber_rx_s r);
    if (!r.seq_ok) begin
      return RX_IGNORE;
    end
    if (r.pool_en && r.quota_nz && r.pool_avail) begin
      if (!r.pool_small) begin
        return RX_USE_POOL;
      end
      if (!r.priv_avail) begin
        return RX_NAK_SMALL;
      end
      return r.priv_small ? RX_NAK_SMALL : RX_USE_PRIV;
    end
    if (!r.priv_avail) begin
      return RX_NAK_UNAVAIL;
    end
    return r.priv_small ? RX_NAK_SMALL : RX_USE_PRIV;
  endfunction

  // Messages are not taken while halted or after shutdown
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_out <= RX_NONE;
      rx_done <= 1'b0;
    end else begin
      rx_done <= rx_in.valid && !halted && state != Q_SHUT;
      if (rx_in.valid && !halted && state != Q_SHUT) begin
        rx_out <= rx_select(rx_in);
      end
    end
  end

  // Counter holds while halted so reads are skew free
  always_ff @(posedge clk) begin
    if (srst) begin
      nak_count <= NAKCNT_RST;
    end else if (rx_in.valid && !halted && state != Q_SHUT &&
                 (rx_select(rx_in) == RX_NAK_SMALL ||
                  rx_select(rx_in) == RX_NAK_UNAVAIL)) begin
      nak_count <= nak_count + 1'b1;
    end
  end

  assign period[0] = babble_period;
  assign period[1] = stream_period;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_tmr
      logic [TMR_W-1:0] cnt;
      always_ff @(posedge clk) begin
        if (srst || !tmr_run[i] || halted) begin
          cnt <= '0;
          tmr_ev[i] <= 1'b0;
        end else begin
          if (cnt != period[i]) begin
            cnt <= cnt + 1'b1;
          end
          // One event per overrun; a zero period disables the monitor
          tmr_ev[i] <= period[i] != '0 && cnt == period[i] - 1'b1;
        end
      end
    end
  endgenerate

  // One response per cycle; nonexistent memory has first claim
  always_comb begin
    push_valid = 1'b1;
    push_data = '0;
    if (nxm_valid) begin
      push_data.kind = RK_NXM;
      push_data.addr = nxm_advanced ? ADDR_W'(nxm_addr + 1'b1) : nxm_addr;
    end else if (perr_valid) begin
      push_data.kind = RK_PROC;
      push_data.code = perr_code;
    end else if (tmr_ev[0]) begin
      push_data.kind = RK_BABBLE;
    end else if (tmr_ev[1]) begin
      push_data.kind = RK_STREAM;
    end else begin
      push_valid = 1'b0;
    end
  end

  assign accept = !fatal && state != Q_SHUT;
  assign push_do = push_valid && accept && count != FULL;
  assign overflow = push_valid && accept && count == FULL;
  assign pop = state == Q_POST && resp_take;

  rxber_mem #(
    .WIDTH(RESP_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .wr_en(push_do),
    .wr_addr(wr_ptr),
    .wr_data(push_data),
    .rd_addr(rd_ptr),
    .rd_data(mem_q)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push_do) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (push_do ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

  // Only a full reset, i.e. the start-up sequence, clears a fatal state
  always_ff @(posedge clk) begin
    if (srst) begin
      fatal <= 1'b0;
    end else if (overflow || (perr_valid && !nxm_valid && perr_code == PERR_FATAL)) begin
      fatal <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= Q_IDLE;
      resp_valid <= 1'b0;
      resp_data <= '0;
      resp_irq <= 1'b0;
      win_cnt <= WIN_RST;
      shut_down <= 1'b0;
    end else begin
      resp_irq <= 1'b0;
      case (state)
        Q_IDLE: begin
          if (count != '0) begin
            state <= Q_FETCH;
          end else if (fatal) begin
            state <= Q_SHUT;
            shut_down <= 1'b1;
          end
        end
        Q_FETCH: begin
          resp_data <= mem_q;
          resp_valid <= 1'b1;
          resp_irq <= 1'b1;
          win_cnt <= WIN_RST;
          state <= Q_POST;
        end
        Q_POST: begin
          if (win_cnt != WIN_LAST) begin
            win_cnt <= win_cnt + 1'b1;
          end
          if (resp_take) begin
            resp_valid <= 1'b0;
            state <= Q_IDLE;
          end else if (fatal && win_cnt == WIN_LAST) begin
            resp_valid <= 1'b0;
            state <= Q_SHUT;
            shut_down <= 1'b1;
          end
        end
        Q_SHUT: begin
          state <= Q_SHUT;
        end
        default: begin
          state <= Q_IDLE;
        end
      endcase
    end
  end

  // Halt set wins over a restart in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      halted <= 1'b0;
      ret_trib_bufs <= 1'b0;
      ret_pool_bufs <= 1'b0;
    end else begin
      ret_trib_bufs <= halt_trib;
      ret_pool_bufs <= halt_global;
      if (halt_trib || halt_global) begin
        halted <= 1'b1;
      end else if (restart) begin
        halted <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      halt_req <= 1'b0;
    end else if (perr_valid && !nxm_valid && perr_code == PERR_HALT) begin
      halt_req <= 1'b1;
    end else if (halt_trib || halt_global) begin
      halt_req <= 1'b0;
    end
  end

  // Power-up is modelled by reset; only the first poll after it counts
  always_ff @(posedge clk) begin
    if (srst) begin
      boot_pend <= 1'b1;
      boot_req <= 1'b0;
    end else begin
      if (poll_rx) begin
        boot_pend <= 1'b0;
      end
      boot_req <= invoke_boot || (poll_rx && boot_pend && power_on_boot_en);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_posted;
    resp_irq && resp_valid;
  endsequence

  property p_note_only;
    perr_valid && !nxm_valid && perr_code >= PERR_NOTE_LO && perr_code <= PERR_NOTE_HI &&
      !fatal && !halt_req |=> !halt_req && !fatal;
  endproperty
  a_note_only: assert property (p_note_only) else $error("notify code changed state");

  property p_halt_code;
    perr_valid && !nxm_valid && perr_code == PERR_HALT |=> halt_req;
  endproperty
  a_halt_code: assert property (p_halt_code) else $error("code 300 not flagged");

  property p_nxm_addr;
    nxm_valid && accept && count != FULL |-> push_do && push_data.kind == RK_NXM &&
      push_data.addr - nxm_addr == ADDR_W'(nxm_advanced);
  endproperty
  a_nxm_addr: assert property (p_nxm_addr) else $error("nxm address wrong");

  property p_seq_ignore;
    rx_in.valid && !rx_in.seq_ok && !halted && state != Q_SHUT |=> rx_done && rx_out == RX_IGNORE;
  endproperty
  a_seq_ignore: assert property (p_seq_ignore) else $error("out of sequence used");

  property p_pool_use;
    rx_in.valid && rx_in.seq_ok && rx_in.pool_en && rx_in.quota_nz && rx_in.pool_avail &&
      !rx_in.pool_small && !halted && state != Q_SHUT |=> rx_out == RX_USE_POOL;
  endproperty
  a_pool_use: assert property (p_pool_use) else $error("pool buffer not used");

  property p_nak_unavail;
    rx_in.valid && rx_in.seq_ok && !rx_in.priv_avail && !(rx_in.pool_en && rx_in.quota_nz &&
      rx_in.pool_avail) && !halted && state != Q_SHUT |=> rx_out == RX_NAK_UNAVAIL;
  endproperty
  a_nak_unavail: assert property (p_nak_unavail) else $error("missing unavailable nak");

  property p_drain_post;
    fatal && state == Q_IDLE && count != '0 |-> ##2 s_posted;
  endproperty
  a_drain_post: assert property (p_drain_post) else $error("no post after overflow");

  property p_shut_hold;
    shut_down |=> shut_down && !resp_valid && state == Q_SHUT;
  endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("left shutdown");

  property p_take_shut;
    fatal && pop && count == (AW+1)'(1) |-> ##2 shut_down;
  endproperty
  a_take_shut: assert property (p_take_shut) else $error("no shutdown after last");

  property p_ret_bufs;
    halt_trib || halt_global |=> halted && ret_trib_bufs == $past(halt_trib) &&
      ret_pool_bufs == $past(halt_global);
  endproperty
  a_ret_bufs: assert property (p_ret_bufs) else $error("buffers not returned");

  property p_freeze;
    halted && $past(halted) |-> $stable(nak_count);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while halted");

  property p_boot_first;
    poll_rx && boot_pend && power_on_boot_en |=> boot_req ##1 !boot_pend;
  endproperty
  a_boot_first: assert property (p_boot_first) else $error("first poll no boot");

endmodule

// ===== rxber_pkg.sv
// Shared types and constants for the receive-buffer and error-recovery engine
package rxber_pkg;

  localparam int ADDR_W = 18;
  localparam int CODE_W = 10;
  localparam int Q_DEPTH = 16;
  localparam int TMR_W = 16;
  localparam int NAKCNT_W = 8;
  localparam int WIN_W = 30;

  // Procedural error codes
  localparam logic [CODE_W-1:0] PERR_NOTE_LO = 10'h064;
  localparam logic [CODE_W-1:0] PERR_NOTE_HI = 10'h08c;
  localparam logic [CODE_W-1:0] PERR_HALT = 10'h12c;
  localparam logic [CODE_W-1:0] PERR_FATAL = 10'h12e;

  // Retrieval window after a fatal queue error
  localparam int RETR_WIN_MS = 3000;
  localparam int CLK_KHZ = 250000;
  localparam int RETR_WIN_CYC = RETR_WIN_MS * CLK_KHZ;

  // Reset values
  localparam logic [NAKCNT_W-1:0] NAKCNT_RST = 8'h00;
  localparam logic [WIN_W-1:0] WIN_RST = 30'h00000000;

  typedef enum logic [2:0] {
    RK_PROC,
    RK_NXM,
    RK_BABBLE,
    RK_STREAM
  } rxber_kind_e;

  typedef enum logic [2:0] {
    RX_NONE,
    RX_IGNORE,
    RX_USE_POOL,
    RX_USE_PRIV,
    RX_NAK_UNAVAIL,
    RX_NAK_SMALL
  } rxber_rx_out_e;

  // Head-of-list view for one arriving message
  typedef struct packed {
    logic valid;
    logic seq_ok;
    logic pool_en;
    logic quota_nz;
    logic pool_avail;
    logic pool_small;
    logic priv_avail;
    logic priv_small;
  } rxber_rx_s;

  typedef struct packed {
    rxber_kind_e kind;
    logic [CODE_W-1:0] code;
    logic [ADDR_W-1:0] addr;
  } rxber_resp_s;

  localparam int RESP_W = $bits(rxber_resp_s);

endpackage

// ===== rxber_mem.sv
// Response queue storage with registered read data
`timescale 1ns/1ps
module rxber_mem #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read of the same word being written returns the old value
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// ===== rxber_host.sv
// Host program model that retrieves posted responses
`timescale 1ns/1ps
module rxber_host
  import rxber_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Response port
  input wire logic resp_valid,
  input wire rxber_resp_s resp_data,
  input wire logic resp_irq,
  output logic resp_take,
  // Pace control
  input wire logic hold,
  input wire logic [7:0] delay,
  // Observed traffic
  output logic [7:0] n_taken,
  output logic [7:0] n_irq,
  output rxber_resp_s last
);
  logic [7:0] wait_cnt;

  always_ff @(posedge clk) begin
    if (srst) begin
      resp_take <= 1'b0;
      n_taken <= 8'h00;
      n_irq <= 8'h00;
      last <= '0;
      wait_cnt <= 8'h00;
    end else begin
      if (resp_irq) begin
        n_irq <= n_irq + 8'h01;
      end
      // Take is held until the edge that sees it with valid
      if (resp_take && resp_valid) begin
        resp_take <= 1'b0;
        n_taken <= n_taken + 8'h01;
        last <= resp_data;
        wait_cnt <= 8'h00;
      end else if (resp_valid && !hold) begin
        if (wait_cnt >= delay) begin
          resp_take <= 1'b1;
        end else begin
          wait_cnt <= wait_cnt + 8'h01;
        end
      end
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the receive-buffer and error-recovery engine
`timescale 1ns/1ps
module testbench
  import rxber_pkg::*;
;
  typedef struct packed {
    rxber_rx_s rx;
    rxber_rx_out_e exp;
  } rxber_row_s;
  rxber_row_s rows [10] = '{
    '{8'h80, RX_IGNORE}, '{8'hb8, RX_IGNORE}, '{8'hf8, RX_USE_POOL},
    '{8'hfe, RX_USE_PRIV}, '{8'hfc, RX_NAK_SMALL}, '{8'hff, RX_NAK_SMALL},
    '{8'hda, RX_USE_PRIV}, '{8'hea, RX_USE_PRIV}, '{8'hf0, RX_NAK_UNAVAIL},
    '{8'hc3, RX_NAK_SMALL}};

  logic clk = 1'b0, srst = 1'b1, hold = 1'b0;
  rxber_rx_s rx_in = '0;
  logic perr_valid = 1'b0, nxm_valid = 1'b0, nxm_advanced = 1'b0;
  logic [CODE_W-1:0] perr_code = '0;
  logic [ADDR_W-1:0] nxm_addr = '0;
  logic [4:0] pul = '0;
  logic [1:0] tmr_run = '0;
  logic [TMR_W-1:0] babble_period = '0, stream_period = '0;
  logic power_on_boot_en = 1'b1;
  rxber_rx_out_e rx_out;
  logic rx_done, resp_take, resp_valid, resp_irq, halted, ret_trib_bufs;
  logic ret_pool_bufs, halt_req, boot_req, fatal, shut_down;
  logic [NAKCNT_W-1:0] nak_count;
  rxber_resp_s resp_data, last;
  logic [7:0] n_taken, n_irq, seen_n, naks;
  int failures = 0, samples_checked = 0, cycles = 0, i, k;

  rxber_core #(.WIN_CYC(40)) i_dut (
    .clk, .srst, .rx_in, .rx_out, .rx_done, .perr_valid, .perr_code,
    .nxm_valid, .nxm_addr, .nxm_advanced, .resp_take, .resp_valid,
    .resp_data, .resp_irq, .halt_trib(pul[0]), .halt_global(pul[1]),
    .restart(pul[2]), .halted, .ret_trib_bufs, .ret_pool_bufs, .halt_req,
    .nak_count, .tmr_run, .babble_period, .stream_period, .poll_rx(pul[3]),
    .power_on_boot_en, .invoke_boot(pul[4]), .boot_req, .fatal, .shut_down
  );

  rxber_host i_host (
    .clk, .srst, .resp_valid, .resp_data, .resp_irq, .resp_take, .hold,
    .delay(8'h03), .n_taken, .n_irq, .last
  );

  always #2 clk = ~clk;

  // Ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic pulse(input int n);
    @(posedge clk);
    pul[n] <= 1'b1;
    @(posedge clk);
    pul[n] <= 1'b0;
    #1;
  endtask

  task automatic send(input rxber_rx_s r, input logic done, input rxber_rx_out_e e);
    @(posedge clk);
    rx_in <= r;
    @(posedge clk);
    rx_in <= '0;
    #1;
    check(rx_done, done);
    check(rx_out, e);
  endtask

  task automatic perr(input logic [CODE_W-1:0] code);
    @(posedge clk);
    perr_valid <= 1'b1;
    perr_code <= code;
    @(posedge clk);
    perr_valid <= 1'b0;
  endtask

  task automatic nxm(input logic [ADDR_W-1:0] a, input logic adv);
    @(posedge clk);
    nxm_valid <= 1'b1;
    nxm_addr <= a;
    nxm_advanced <= adv;
    @(posedge clk);
    nxm_valid <= 1'b0;
  endtask

  task automatic wait_take;
    k = 0;
    while (n_taken === seen_n && k < 300) begin
      @(posedge clk);
      k++;
    end
    #1;
    check(n_taken, seen_n + 8'h01);
    seen_n = n_taken;
  endtask

  task automatic wait_shut;
    k = 0;
    while (shut_down !== 1'b1 && k < 500) begin
      @(posedge clk);
      k++;
    end
    #1;
    check(shut_down, 1'b1);
  endtask

  initial begin
    seen_n = 8'h00;
    naks = 8'h00;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({rx_done, resp_valid, halted, fatal, shut_down, boot_req}, '0);
    check(rx_out, RX_NONE);
    $display("reset test done");
    pulse(3);
    check(boot_req, 1'b1);
    pulse(3);
    check(boot_req, 1'b0);
    pulse(4);
    check(boot_req, 1'b1);
    $display("boot test done");
    foreach (rows[j]) begin
      send(rows[j].rx, 1'b1, rows[j].exp);
      if (rows[j].exp inside {RX_NAK_SMALL, RX_NAK_UNAVAIL}) begin
        naks++;
      end
    end
    check(nak_count, naks);
    $display("buffer selection table done");
    perr(PERR_NOTE_LO);
    wait_take();
    check({last.kind, last.code}, {RK_PROC, PERR_NOTE_LO});
    perr(PERR_NOTE_HI);
    wait_take();
    check({last.kind, last.code}, {RK_PROC, PERR_NOTE_HI});
    nxm(18'h3fffe, 1'b1);
    wait_take();
    check({last.kind, last.addr}, {RK_NXM, 18'h3ffff});
    nxm(18'h00123, 1'b0);
    wait_take();
    check({last.kind, last.addr}, {RK_NXM, 18'h00123});
    check({halted, halt_req, fatal}, '0);
    $display("error report test done");
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      babble_period <= 16'h0005;
      stream_period <= 16'h0005;
      tmr_run <= 2'b01 << i;
      wait_take();
      @(posedge clk);
      tmr_run <= 2'b00;
      check(last.kind, i ? RK_STREAM : RK_BABBLE);
      repeat (40) @(posedge clk);
      seen_n = n_taken;
    end
    $display("monitor timer test done");
    perr(PERR_HALT);
    @(posedge clk);
    #1;
    check(halt_req, 1'b1);
    repeat (20) @(posedge clk);
    seen_n = n_taken;
    // Host recovery: halt, inspect, restart
    pulse(0);
    check({ret_trib_bufs, halted, halt_req}, 3'b110);
    send(8'hc0, 1'b0, RX_NAK_SMALL);
    check(nak_count, naks);
    pulse(1);
    check(ret_pool_bufs, 1'b1);
    pulse(2);
    check(halted, 1'b0);
    check(n_irq, n_taken);
    $display("halt test done");
    @(posedge clk);
    hold <= 1'b1;
    for (i = 0; i < 17; i++) begin
      nxm_valid <= 1'b1;
      nxm_addr <= 18'h00100 + 18'(i);
      @(posedge clk);
    end
    nxm_valid <= 1'b0;
    hold <= 1'b0;
    @(posedge clk);
    #1;
    check(fatal, 1'b1);
    wait_shut();
    check(n_taken - seen_n, 8'h10);
    check(last.addr, 18'h0010f);
    send(8'hf8, 1'b0, RX_NAK_SMALL);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    check({shut_down, fatal}, 2'b00);
    @(posedge clk);
    power_on_boot_en <= 1'b0;
    pulse(3);
    check(boot_req, 1'b0);
    // Remote load detect is started from the control station alone
    repeat (4) @(posedge clk);
    #1;
    check(boot_req, 1'b0);
    seen_n = 8'h00;
    $display("overflow drain test done");
    @(posedge clk);
    hold <= 1'b1;
    perr(PERR_FATAL);
    @(posedge clk);
    #1;
    check(fatal, 1'b1);
    wait_shut();
    check(k > 30 && k < 55, 1'b1);
    check({resp_valid, n_taken}, 9'h000);
    $display("window lapse test done");
    end_of_test();
  end
endmodule
